// File: design/ifs_pkg.sv
// constants and types shared by the two-wire slave and its receive buffer
package ifs_pkg;

  // frame layout
  localparam int          IFS_DATA_BITS   = 8;     // data bits in one frame
  localparam int          IFS_ADDR_BITS   = 7;     // slave address width
  localparam logic [3:0]  IFS_CNT_ACK     = 4'h8;  // count value before 9th rising edge
  localparam logic [3:0]  IFS_CNT_END     = 4'h9;  // count value after 9th rising edge
  localparam int          IFS_PIN_LINES   = 3;     // scl, sda and formatless clock pins
  localparam int          IFS_RX_DEPTH    = 2;     // receive buffer entries

  // reset values
  localparam logic        IFS_FLAG_RST    = 1'b0;  // all flags clear after reset
  localparam logic        IFS_LINE_IDLE   = 1'b1;  // released bus line level
  localparam logic        IFS_ACK_RST     = 1'b1;  // acknowledge bit before any frame
  localparam logic        IFS_PIN_DRIVE   = 1'b0;  // open-drain pins only ever drive low

  // bus sequencer states
  typedef enum logic [2:0] {
    IFS_ST_IDLE,
    IFS_ST_ADDR,
    IFS_ST_RX,
    IFS_ST_TX,
    IFS_ST_IGNORE
  } ifs_state_t;

endpackage

// File: design/ifs_buf_if.sv
// valid/ready carrier between the slave and its receive buffer
`timescale 1ns/100ps
interface ifs_buf_if #(parameter int WIDTH = 8);
  logic             wr_valid;  // byte offered by the slave
  logic             wr_ready;  // buffer has room
  logic [WIDTH-1:0] wr_data;   // byte offered
  logic             rd_valid;  // head entry holds a byte
  logic             rd_ready;  // software takes the head byte
  logic [WIDTH-1:0] rd_data;   // head byte, registered
  logic             flush;     // forced initialization empties the buffer

  modport store (input wr_valid, input wr_data, input rd_ready, input flush,
                 output wr_ready, output rd_valid, output rd_data);
  modport user  (output wr_valid, output wr_data, output rd_ready, output flush,
                 input wr_ready, input rd_valid, input rd_data);
endinterface

// File: design/ifs_buf.sv
// small shifting buffer with a registered head entry
`timescale 1ns/100ps
module ifs_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // buffer port
  ifs_buf_if.store  bif
);
  import ifs_pkg::*;

  logic [WIDTH-1:0]         mem_r [DEPTH];  // entry 0 is the head register
  logic [$clog2(DEPTH+1)-1:0] cnt_r;        // entries in use
  logic                     valid_r;        // head valid, kept as a flop
  logic                     push;           // accepted write
  logic                     pop;            // accepted read

  assign push          = bif.wr_valid && bif.wr_ready;
  assign pop           = bif.rd_valid && bif.rd_ready;
  assign bif.wr_ready  = (cnt_r < ($clog2(DEPTH+1))'(DEPTH)) || pop;
  assign bif.rd_valid  = valid_r;
  assign bif.rd_data   = mem_r[0];

  // occupancy; a pop frees room in the same cycle so a full buffer never stalls twice
  always_ff @(posedge clk) begin
    if (!rst_b || bif.flush) begin
      cnt_r   <= '0;
      valid_r <= 1'b0;
    end else begin
      cnt_r   <= cnt_r + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
      valid_r <= (cnt_r + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0)) != '0;
    end
  end

  // storage shifts toward the head on a pop
  always_ff @(posedge clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (pop && (i < DEPTH - 1)) begin
        mem_r[i] <= mem_r[i+1];
      end
      if (push && (int'(cnt_r) - (pop ? 1 : 0) == i)) begin
        mem_r[i] <= bif.wr_data;
      end
    end
  end

endmodule

// File: design/ifs_slave.sv
// two-wire bus slave with formatless switch, noise canceler and forced init
`timescale 1ns/100ps
module ifs_slave #(
  parameter int ADDR_BITS = ifs_pkg::IFS_ADDR_BITS,
  parameter int RX_DEPTH  = ifs_pkg::IFS_RX_DEPTH
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // bus pins, open drain
  input  wire logic                 scl_in,
  output logic                      scl_out,
  output logic                      scl_oe,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe,
  input  wire logic                 formatless_clock_pin,
  // control
  input  wire logic                 iface_enable,
  input  wire logic                 clear_control_strobe,
  input  wire logic                 bit_order_select,
  input  wire logic                 transfer_irq_enable,
  input  wire logic                 transfer_irq_clear,
  input  wire logic                 transmit_irq_clear,
  input  wire logic                 transmit_select_wr,
  input  wire logic                 transmit_select_val,
  input  wire logic                 formatless_switch_set,
  input  wire logic [ADDR_BITS-1:0] slave_addr_reg_a,
  input  wire logic [ADDR_BITS-1:0] slave_addr_reg_b,
  // transmit data write
  input  wire logic                 tx_wr,
  input  wire logic [7:0]           tx_data,
  // receive data read
  output logic                      rx_valid,
  input  wire logic                 rx_ready,
  output logic [7:0]                rx_data,
  // status
  output logic                      bus_busy_flag,
  output logic                      transfer_irq_flag,
  output logic                      transmit_irq_flag,
  output logic                      irq_req,
  output logic                      ack_bit,
  output logic                      transmit_select,
  output logic                      formatless_switch,
  output logic                      receive_full_flag,
  output logic                      transmit_empty_flag,
  output logic                      formatless_clock_level
);
  import ifs_pkg::*;

  // pin conditioning
  logic [IFS_PIN_LINES-1:0] pin_raw;       // scl, sda, formatless clock
  logic [IFS_PIN_LINES-1:0] sync1_r;       // first synchroniser stage
  logic [IFS_PIN_LINES-1:0] sync2_r;       // second stage, also first canceler latch
  logic [IFS_PIN_LINES-1:0] latch_r;       // second canceler latch
  logic [IFS_PIN_LINES-1:0] filt_r;        // filtered level
  logic [IFS_PIN_LINES-1:0] filt_d_r;      // filtered level one cycle ago
  logic                     scl_rise;      // filtered scl edges
  logic                     scl_fall;
  logic                     start_det;     // sda falls while scl high
  logic                     stop_det;      // sda rises while scl high

  // sequencer
  ifs_state_t               state_r;       // bus sequencer state
  logic [3:0]               bit_cnt_r;     // rising edges seen in this frame
  logic [7:0]               shift_r;       // bus shift register
  logic [7:0]               rx_byte_r;     // byte waiting for the buffer
  logic                     rx_pend_r;     // byte offered to the buffer
  logic                     tx_wait_r;     // frame done, waiting for a byte to send
  logic                     scl_hold_r;    // stretch the clock line
  logic                     sda_low_r;     // pull the data line low
  logic                     frame_evt;     // ninth rising edge of a counted frame
  logic                     tx_enter;      // address read bit accepted
  logic                     tx_load;       // held byte moves into the shifter

  // software side
  logic [7:0]               tx_hold_r;     // data register for transmit
  logic                     tx_empty_r;
  logic                     busy_r;
  logic                     xfer_irq_r;
  logic                     xmit_irq_r;
  logic                     irq_r;
  logic                     ack_r;
  logic                     txsel_r;
  logic                     fl_sw_r;       // formatless mode active
  logic                     defer_r;       // formatless left, stop not yet seen
  logic                     rx_full_r;
  logic                     force_init;    // forced initialization
  logic                     bus_off;       // bus frames not handled

  ifs_buf_if #(.WIDTH(8)) bif ();

  // address match against both programmable addresses
  function automatic logic addr_hit(input logic [ADDR_BITS-1:0] a,
                                    input logic [ADDR_BITS-1:0] ra,
                                    input logic [ADDR_BITS-1:0] rb);
    return (a == ra) || (a == rb);
  endfunction

  // place one received bit at the end selected by the bit order
  function automatic logic [7:0] shift_in(input logic [7:0] s, input logic b,
                                          input logic lsb_first);
    return lsb_first ? {b, s[7:1]} : {s[6:0], b};
  endfunction

  // bit to put on the line next, taken from the leading end
  function automatic logic lead_bit(input logic [7:0] s, input logic lsb_first);
    return lsb_first ? s[0] : s[7];
  endfunction

  // bit order: address frame always msb first, data as selected
  function automatic logic [7:0] shift_out(input logic [7:0] s, input logic lsb_first);
    return lsb_first ? {1'b1, s[7:1]} : {s[6:0], 1'b1};
  endfunction

  assign pin_raw    = {formatless_clock_pin, sda_in, scl_in};
  assign force_init = clear_control_strobe || !iface_enable;
  assign bus_off    = fl_sw_r || defer_r;

  // sync and noise canceler, one copy per pin
  genvar g;
  generate
    for (g = 0; g < IFS_PIN_LINES; g++) begin : g_pin
      // two flops before anything reads the pin, then a second latch for the match
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          sync1_r[g]  <= IFS_LINE_IDLE;
          sync2_r[g]  <= IFS_LINE_IDLE;
          latch_r[g]  <= IFS_LINE_IDLE;
          filt_r[g]   <= IFS_LINE_IDLE;
          filt_d_r[g] <= IFS_LINE_IDLE;
        end else begin
          sync1_r[g]  <= pin_raw[g];
          sync2_r[g]  <= sync1_r[g];
          latch_r[g]  <= sync2_r[g];
          // a glitch shorter than two clocks never agrees, so the old level holds
          if (sync2_r[g] == latch_r[g]) begin
            filt_r[g] <= latch_r[g];
          end
          filt_d_r[g] <= filt_r[g];
        end
      end
    end
  endgenerate

  assign scl_rise  = filt_r[0] && !filt_d_r[0];
  assign scl_fall  = !filt_r[0] && filt_d_r[0];
  assign start_det = filt_r[0] && filt_d_r[0] && !filt_r[1] && filt_d_r[1];
  assign stop_det  = filt_r[0] && filt_d_r[0] && filt_r[1] && !filt_d_r[1];

  // events decoded from the sequencer state
  assign frame_evt = scl_rise && (bit_cnt_r == IFS_CNT_ACK) && !bus_off &&
                     ((state_r == IFS_ST_RX) || (state_r == IFS_ST_TX) ||
                      ((state_r == IFS_ST_ADDR) &&
                       addr_hit(shift_r[7:1], slave_addr_reg_a, slave_addr_reg_b)));
  assign tx_enter  = scl_fall && (state_r == IFS_ST_ADDR) && (bit_cnt_r == IFS_CNT_END)
                     && shift_r[0] && !bus_off;
  assign tx_load   = (state_r == IFS_ST_TX) && tx_wait_r && !tx_empty_r && !stop_det;

  // bus sequencer: frames, acknowledge, clock stretching
  always_ff @(posedge clk) begin
    if (!rst_b || force_init) begin
      state_r    <= IFS_ST_IDLE;
      bit_cnt_r  <= '0;
      shift_r    <= '0;
      rx_byte_r  <= '0;
      rx_pend_r  <= 1'b0;
      tx_wait_r  <= 1'b0;
      scl_hold_r <= 1'b0;
      sda_low_r  <= 1'b0;
    end else begin
      // a waiting byte leaves as soon as the buffer has room; the stretch ends with it
      if (rx_pend_r && bif.wr_ready) begin
        rx_pend_r  <= 1'b0;
        scl_hold_r <= 1'b0;
      end
      if (stop_det || bus_off) begin
        // stop frees both lines; formatless mode never touches the bus clock
        state_r    <= IFS_ST_IDLE;
        tx_wait_r  <= 1'b0;
        scl_hold_r <= 1'b0;
        sda_low_r  <= 1'b0;
      end else if (start_det) begin
        state_r   <= IFS_ST_ADDR;
        bit_cnt_r <= '0;
        sda_low_r <= 1'b0;
        tx_wait_r <= 1'b0;
      end else begin
        case (state_r)
          IFS_ST_ADDR, IFS_ST_RX: begin
            if (scl_rise) begin
              if (bit_cnt_r < IFS_CNT_ACK) begin
                shift_r <= shift_in(shift_r, filt_r[1],
                                    bit_order_select && (state_r == IFS_ST_RX));
              end
              bit_cnt_r <= bit_cnt_r + 4'h1;
              if (frame_evt && (state_r == IFS_ST_RX)) begin
                rx_byte_r <= shift_r;
                rx_pend_r <= 1'b1;
              end
            end else if (scl_fall && (bit_cnt_r == IFS_CNT_ACK)) begin
              if ((state_r == IFS_ST_RX) ||
                  addr_hit(shift_r[7:1], slave_addr_reg_a, slave_addr_reg_b)) begin
                sda_low_r <= 1'b1;
              end else begin
                state_r <= IFS_ST_IGNORE;
              end
            end else if (scl_fall && (bit_cnt_r == IFS_CNT_END)) begin
              sda_low_r <= 1'b0;
              bit_cnt_r <= '0;
              if (state_r == IFS_ST_ADDR && shift_r[0]) begin
                state_r    <= IFS_ST_TX;
                tx_wait_r  <= 1'b1;
                scl_hold_r <= 1'b1;
              end else begin
                state_r <= IFS_ST_RX;
                // previous byte still not taken: stretch until the reader frees room
                if (rx_pend_r && !bif.wr_ready) begin
                  scl_hold_r <= 1'b1;
                end
              end
            end
          end
          IFS_ST_TX: begin
            if (tx_load) begin
              shift_r    <= shift_out(tx_hold_r, bit_order_select);
              sda_low_r  <= !lead_bit(tx_hold_r, bit_order_select);
              tx_wait_r  <= 1'b0;
              scl_hold_r <= 1'b0;
            end else if (scl_rise) begin
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && (bit_cnt_r < IFS_CNT_ACK) && !tx_wait_r) begin
              // an all-ones byte leaves the line released for the master's stop
              sda_low_r <= !lead_bit(shift_r, bit_order_select);
              shift_r   <= shift_out(shift_r, bit_order_select);
            end else if (scl_fall && (bit_cnt_r == IFS_CNT_ACK)) begin
              sda_low_r <= 1'b0;
            end else if (scl_fall && (bit_cnt_r == IFS_CNT_END)) begin
              bit_cnt_r <= '0;
              if (ack_r) begin
                state_r <= IFS_ST_IGNORE;
              end else begin
                tx_wait_r  <= 1'b1;
                scl_hold_r <= tx_empty_r;
              end
            end
          end
          IFS_ST_IGNORE: begin
            sda_low_r <= 1'b0;
          end
          default: begin
            sda_low_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // transmit data register and empty flag
  always_ff @(posedge clk) begin
    if (!rst_b || force_init) begin
      tx_empty_r <= IFS_FLAG_RST;
    end else if (tx_enter || tx_load) begin
      tx_empty_r <= 1'b1;
    end else if (tx_wr && txsel_r) begin
      tx_empty_r <= 1'b0;
    end
  end

  // data register keeps its value through forced initialization
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_hold_r <= '0;
    end else if (tx_wr) begin
      tx_hold_r <= tx_data;
    end
  end

  // bus busy follows start and stop only
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busy_r <= IFS_FLAG_RST;
    end else if (start_det) begin
      busy_r <= 1'b1;
    end else if (stop_det) begin
      busy_r <= 1'b0;
    end
  end

  // interrupt flags: a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      xfer_irq_r <= IFS_FLAG_RST;
      xmit_irq_r <= IFS_FLAG_RST;
      irq_r      <= IFS_FLAG_RST;
    end else begin
      if (frame_evt || tx_load) begin
        xfer_irq_r <= 1'b1;
      end else if (transfer_irq_clear) begin
        xfer_irq_r <= 1'b0;
      end
      if (tx_load) begin
        xmit_irq_r <= 1'b1;
      end else if (transmit_irq_clear) begin
        xmit_irq_r <= 1'b0;
      end
      irq_r <= (xfer_irq_r || frame_evt || tx_load) && transfer_irq_enable;
    end
  end

  // acknowledge from the master sampled on the ninth rising edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ack_r <= IFS_ACK_RST;
    end else if (frame_evt && (state_r == IFS_ST_TX)) begin
      ack_r <= filt_r[1];
    end
  end

  // transmit select: hardware changes win over a software write
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      txsel_r <= IFS_FLAG_RST;
    end else if (fl_sw_r && scl_fall) begin
      txsel_r <= 1'b0;
    end else if (tx_enter) begin
      txsel_r <= 1'b1;
    end else if (transmit_select_wr) begin
      txsel_r <= transmit_select_val;
    end
  end

  // formatless mode: the first bus clock fall leaves it, then wait for a stop
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fl_sw_r <= IFS_FLAG_RST;
      defer_r <= IFS_FLAG_RST;
    end else begin
      if (fl_sw_r && scl_fall) begin
        fl_sw_r <= 1'b0;
        defer_r <= 1'b1;
      end else if (formatless_switch_set) begin
        fl_sw_r <= 1'b1;
      end else if (stop_det) begin
        defer_r <= 1'b0;
      end
    end
  end

  // receive full mirrors a buffer with no room or a byte still waiting
  always_ff @(posedge clk) begin
    if (!rst_b || force_init) begin
      rx_full_r <= IFS_FLAG_RST;
    end else begin
      rx_full_r <= !bif.wr_ready || rx_pend_r;
    end
  end

  // pin drivers: outputs are always low, the enable decides
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scl_out <= IFS_PIN_DRIVE;
      sda_out <= IFS_PIN_DRIVE;
      scl_oe  <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      scl_out <= IFS_PIN_DRIVE;
      sda_out <= IFS_PIN_DRIVE;
      scl_oe  <= scl_hold_r && !bus_off && !force_init;
      sda_oe  <= sda_low_r && !bus_off && !force_init;
    end
  end

  // status outputs, all registered
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bus_busy_flag          <= IFS_FLAG_RST;
      transfer_irq_flag      <= IFS_FLAG_RST;
      transmit_irq_flag      <= IFS_FLAG_RST;
      irq_req                <= IFS_FLAG_RST;
      ack_bit                <= IFS_ACK_RST;
      transmit_select        <= IFS_FLAG_RST;
      formatless_switch      <= IFS_FLAG_RST;
      receive_full_flag      <= IFS_FLAG_RST;
      transmit_empty_flag    <= IFS_FLAG_RST;
      formatless_clock_level <= IFS_LINE_IDLE;
    end else begin
      bus_busy_flag          <= busy_r;
      transfer_irq_flag      <= xfer_irq_r;
      transmit_irq_flag      <= xmit_irq_r;
      irq_req                <= irq_r;
      ack_bit                <= ack_r;
      transmit_select        <= txsel_r;
      formatless_switch      <= fl_sw_r;
      receive_full_flag      <= rx_full_r;
      transmit_empty_flag    <= tx_empty_r;
      formatless_clock_level <= filt_r[2];
    end
  end

  // receive buffer; a slow reader stalls the bus clock instead of losing bytes
  assign bif.wr_valid = rx_pend_r;
  assign bif.wr_data  = rx_byte_r;
  assign bif.rd_ready = rx_ready;
  assign bif.flush    = force_init;
  assign rx_valid     = bif.rd_valid;
  assign rx_data      = bif.rd_data;

  ifs_buf #(
    .WIDTH (8),
    .DEPTH (RX_DEPTH)
  ) u_rx_buf (
    .clk   (clk),
    .rst_b (rst_b),
    .bif   (bif)
  );

endmodule

// File: design/ifs_slave_end.sv
// spare design file, holds no logic

// File: bench/ifs_slave_props.sv
// port assertions for the two-wire slave
`timescale 1ns/100ps
module ifs_slave_props (
  // clock, reset and pins
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_oe,
  input wire logic sda_oe,
  // control and status
  input wire logic iface_enable,
  input wire logic transfer_irq_enable,
  input wire logic tx_wr,
  input wire logic transmit_select,
  input wire logic formatless_switch,
  input wire logic bus_busy_flag,
  input wire logic transfer_irq_flag,
  input wire logic transmit_irq_flag,
  input wire logic irq_req,
  input wire logic receive_full_flag,
  input wire logic transmit_empty_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_start_sets_busy: assert property ($rose(bus_busy_flag) |-> scl_in && !sda_in)
    else $error("busy rose without start");
  a_stop_clears_busy: assert property ($fell(bus_busy_flag) |-> scl_in && sda_in)
    else $error("busy fell without stop");
  a_irq_gated: assert property ((!transfer_irq_enable)[*3] |-> !irq_req)
    else $error("request while disabled");
  a_stretch_cause: assert property ($rose(scl_oe) |->
    receive_full_flag || transmit_empty_flag)
    else $error("clock held with no cause");
  a_fmt_no_drive: assert property (formatless_switch |-> !scl_oe)
    else $error("clock driven in formatless mode");
  a_fmt_exit: assert property ($fell(formatless_switch) |->
    !scl_in ##[0:3] !transmit_select)
    else $error("bad formatless exit");
  a_init_release: assert property ((!iface_enable)[*3] |->
    !scl_oe && !sda_oe && !receive_full_flag && !transmit_empty_flag)
    else $error("init left state");
  a_write_reload: assert property (tx_wr && transmit_select |->
    ##[1:6] transmit_irq_flag && transfer_irq_flag)
    else $error("write gave no reload");
endmodule

bind ifs_slave ifs_slave_props i_ifs_slave_props (.*);

// File: bench/ifs_bus_master.sv
// behavioural bus master on the clock and data lines
`timescale 1ns/100ps
module ifs_bus_master (
  // lines as seen on the wire
  input  wire logic scl,
  input  wire logic sda,
  // drive, 1 = released to pull-up
  output logic      scl_o,
  output logic      sda_o
);
  localparam int HALF = 400; // half bit time, ns
  // idle released, clock never pulled while unused
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // release clock, bounded wait while the slave stretches
  task automatic rise();
    scl_o = 1'b1;
    for (int i = 0; i < 400 && scl !== 1'b1; i++) #50;
  endtask
  // data falls while clock high
  task automatic start();
    rise();
    #HALF;
    sda_o = 1'b0;
    #HALF;
    scl_o = 1'b0;
  endtask
  // data rises while clock high
  task automatic stop();
    sda_o = 1'b0;
    #HALF;
    rise();
    #HALF;
    sda_o = 1'b1;
    #HALF;
  endtask
  // nine bits msb first; last is the acknowledge slot
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      sda_o = d[i];
      #HALF;
      rise();
      #HALF;
      q[i] = sda;
      scl_o = 1'b0;
    end
  endtask
endmodule

// File: bench/ifs_slave_tb.sv
// bench: master model on the pins, software side driven by tasks
`timescale 1ns/100ps
module ifs_slave_tb;
  import ifs_pkg::*;
  localparam logic [6:0] AA = 7'h2a; // first slave address
  localparam logic [6:0] AB = 7'h51; // second slave address
  logic       clk = 1'b0, rst_b = 1'b0, iface_enable = 1'b1, clear_control_strobe = 1'b0;
  logic       bit_order_select = 1'b0, transfer_irq_enable = 1'b1, tx_wr = 1'b0;
  logic       transfer_irq_clear = 1'b0, transmit_irq_clear = 1'b0, rx_ready = 1'b0;
  logic       transmit_select_wr = 1'b0, transmit_select_val = 1'b1;
  logic       formatless_switch_set = 1'b0, formatless_clock_pin = 1'b1;
  logic [6:0] slave_addr_reg_a = AA, slave_addr_reg_b = AB;
  logic [7:0] tx_data = 8'h00, rx_data;
  logic       scl_out, scl_oe, sda_out, sda_oe, rx_valid, bus_busy_flag, transfer_irq_flag;
  logic       transmit_irq_flag, irq_req, ack_bit, transmit_select, formatless_switch;
  logic       receive_full_flag, transmit_empty_flag, formatless_clock_level, m_scl, m_sda;
  logic [8:0] q; // bits the master saw
  int         n_errors = 0, checked = 0, cyc = 0;
  wire        scl = m_scl & (scl_out | !scl_oe); // pulled-up open-drain lines
  wire        sda = m_sda & (sda_out | !sda_oe);
  ifs_slave i_ifs_slave (.scl_in(scl), .sda_in(sda), .*);
  ifs_bus_master i_m (.scl(scl), .sda(sda), .scl_o(m_scl), .sda_o(m_sda));
  always #25 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic pulse(ref logic s);
    tick();
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask
  // one frame by the master, all nine sampled bits compared
  task automatic frame(input logic [8:0] d, input logic [8:0] e);
    i_m.xfer(d, q);
    chk("frame", e, q);
  endtask
  // take the head byte and clear the flag together
  task automatic rd(input logic [7:0] e);
    for (int i = 0; i < 200 && rx_valid !== 1'b1; i++) tick();
    rx_ready = 1'b1;
    transfer_irq_clear = 1'b1;
    chk("rx_data", {e, 1'b0}, {rx_data, 1'b0});
    tick();
    rx_ready = 1'b0;
    transfer_irq_clear = 1'b0;
    tick();
  endtask
  // transfer flag cleared first, then the byte written
  task automatic wr(input logic [7:0] d);
    pulse(transfer_irq_clear);
    tx_data = d;
    pulse(tx_wr);
  endtask
  task automatic final_report();
    if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) tick();
    rst_b = 1'b1;
    repeat (8) tick();
    i_m.start();
    chk("busy", 9'h1, bus_busy_flag);
    frame({AA, 1'b0, 1'b1}, {AA, 1'b0, 1'b0});
    chk("irq", 9'h3, {transfer_irq_flag, irq_req});
    frame({8'ha5, 1'b1}, {8'ha5, 1'b0});
    bit_order_select = 1'b1;
    frame({8'h01, 1'b1}, {8'h01, 1'b0});
    bit_order_select = 1'b0;
    frame({8'h5a, 1'b1}, {8'h5a, 1'b0});
    #600;
    chk("hold", 9'h1, scl_oe);
    rd(8'ha5);
    rd(8'h80);
    rd(8'h5a);
    i_m.stop();
    chk("busy", 9'h0, bus_busy_flag);
    i_m.start();
    frame({7'h55, 1'b0, 1'b1}, {7'h55, 1'b0, 1'b1});
    frame({8'h00, 1'b1}, {8'h00, 1'b1});
    chk("nomatch", 9'h0, transfer_irq_flag);
    i_m.stop();
    transfer_irq_enable = 1'b0;
    i_m.start();
    frame({AB, 1'b1, 1'b1}, {AB, 1'b1, 1'b0});
    repeat (8) tick(); // 9th fall takes about six clocks to show in the flags
    chk("tx", 9'h3, {transmit_select, transmit_empty_flag});
    fork
      frame({8'hff, 1'b0}, {8'h96, 1'b0});
      begin #2000; wr(8'h96); end
    join
    chk("ack_bit", 9'h0, ack_bit);
    chk("tx_irq", 9'h3, {transmit_irq_flag, transfer_irq_flag});
    fork
      frame({8'hff, 1'b1}, {8'hff, 1'b1});
      begin #2000; wr(8'hff); end
    join
    chk("ack_bit", 9'h1, ack_bit);
    pulse(transmit_irq_clear);
    repeat (2) tick();
    chk("tx_irq_clr", 9'h0, transmit_irq_flag);
    i_m.stop();
    pulse(transmit_select_wr);
    pulse(formatless_switch_set);
    formatless_clock_pin = 1'b0; // level passes sync and canceler in about five clocks
    repeat (6) tick();
    chk("fmt", 9'h6, {formatless_switch, transmit_select, formatless_clock_level});
    formatless_clock_pin = 1'b1;
    i_m.start();
    frame({AA, 1'b0, 1'b1}, {AA, 1'b0, 1'b1});
    chk("fmt", 9'h1, {formatless_switch, transmit_select, formatless_clock_level});
    i_m.stop();
    i_m.start();
    frame({AA, 1'b0, 1'b1}, {AA, 1'b0, 1'b0});
    pulse(clear_control_strobe);
    i_m.stop();
    iface_enable = 1'b0;
    repeat (4) tick();
    chk("keep", 9'h1, transfer_irq_flag);
    final_report();
  end
endmodule
